// [hw/pit_core.sv]
`include "pit_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_core
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // decoded instruction entering address calculation
  input wire pit_pkg::pit_instr_t ac_instr,
  input wire pit_pkg::pit_rep_t rep,
  // cache reference interlock from outside
  input wire logic cache_interlock,
  // pipeline control
  output logic cycle_en,
  output logic hold_front,
  output logic advance_back,
  output logic [3:0] stall_left,
  // timing report for the instruction accepted
  output logic time_valid,
  output logic [15:0] exec_time,
  output logic mode_illegal,
  output logic cache_bypass
);
  import pit_pkg::*;

  // ****************************************
  // processor cycle enable
  // ****************************************
  logic phase_q;
  always_ff @(posedge mclk)
  begin
    if (srst)
      phase_q <= 1'b0;
    else
      phase_q <= ~phase_q;
  end
  // two phases make one processor cycle
  assign cycle_en = phase_q;

  // ****************************************
  // interlock detection
  // ****************************************
  // writers one and two cycles ahead of address calculation
  pit_instr_t ex1_q;
  pit_instr_t ex2_q;

  function automatic logic [15:0] pit_writes(input pit_instr_t i);
    // multi-register writers cover every register
    pit_writes = !i.valid ? 16'h0000 :
                 i.multi_write ? 16'hffff : i.wr_mask;
  endfunction

  // masks are per longword register, so byte/word parts fold in
  wire [15:0] hit1 = pit_writes(ex1_q) & ac_instr.ac_mask;
  wire [15:0] hit2 = pit_writes(ex2_q) & ac_instr.ac_mask;
  wire ilk_adj = ac_instr.valid && (|hit1);
  wire ilk_gap = ac_instr.valid && (|hit2);
  wire [3:0] stall_need = ilk_adj ? `PIT_STALL_ADJACENT :
                          ilk_gap ? `PIT_STALL_GAP_ONE : 4'h0;

  logic [3:0] stall_q;
  logic [3:0] stall_d;
  wire stalling = (stall_q != 4'h0);
  wire fresh = ac_instr.valid && !stalling;
  // a fresh request is checked once; stall counts down per cycle
  always_comb
  begin
    stall_d = stall_q;
    if (cycle_en)
    begin
      if (stalling)
        stall_d = stall_q - 4'h1;
      else if (fresh && !cache_interlock && stall_need != 4'h0)
        // the detecting cycle is itself held, so load one less
        stall_d = stall_need - 4'h1;
    end
  end

  // only one instruction waits per source of delay
  assign hold_front = stalling || cache_interlock ||
                      (fresh && stall_need != 4'h0);
  // later stages keep flowing so the blocking write lands
  assign advance_back = cycle_en;
  assign stall_left = stall_q;

  wire accept = cycle_en && ac_instr.valid && !hold_front;
  // bubbles enter the back stages while the front is held
  wire pit_instr_t ex_in = accept ? ac_instr : '0;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      stall_q <= 4'h0;
      ex1_q <= '0;
      ex2_q <= '0;
    end
    else
    begin
      stall_q <= stall_d;
      if (cycle_en)
      begin
        ex1_q <= ex_in;
        ex2_q <= ex1_q;
      end
    end
  end

  // ****************************************
  // execution time
  // ****************************************
  logic [7:0] mode_cost;
  logic illegal_w;
  pit_mode_cost u_mode_cost
  (
    .mode(ac_instr.mode),
    .rel_indexed(ac_instr.rel_indexed),
    .imm_long(ac_instr.imm_long),
    .ext_words(ac_instr.ext_words),
    .rep(rep),
    .cost(mode_cost),
    .illegal(illegal_w)
  );

  wire [15:0] it = {8'h00, ac_instr.iters};
  wire [15:0] blk_rep = {8'h00, `PIT_CYC_BLK_REP_BASE} +
                        16'(it * {8'h00, `PIT_CYC_BLK_REP_STEP});
  wire [15:0] str_rep = {8'h00, `PIT_CYC_STR_REP_BASE} +
                        16'(it * {8'h00, `PIT_CYC_STR_REP_STEP});
  wire [7:0] div_w = (ac_instr.div_case == 2'h0) ? `PIT_DIVW_C1 :
                     (ac_instr.div_case == 2'h1) ? `PIT_DIVW_C2 :
                     `PIT_DIVW_C3;
  wire [7:0] div_l = (ac_instr.div_case == 2'h0) ? `PIT_LONG_SIGNED_QUOTIENT_C1 :
                     (ac_instr.div_case == 2'h1) ? `PIT_LONG_SIGNED_QUOTIENT_C2 :
                     `PIT_LONG_SIGNED_QUOTIENT_C3;
  wire [15:0] mc = {8'h00, mode_cost};

  logic [15:0] time_d;
  always_comb
  begin
    unique case (ac_instr.op)
      pit_op_simple: time_d = {8'h00, ac_instr.op_cycles} + mc;
      pit_op_bounds_check: time_d = {8'h00, `PIT_CYC_CHECK} + mc;
      pit_op_decrement_interlocked:
        time_d = {8'h00, `PIT_CYC_DEC_ILK};
      pit_op_div:
        time_d = {8'h00, ac_instr.is_long ? div_l : div_w} + mc;
      pit_op_block_compare:
        time_d = {8'h00, `PIT_CYC_BLK_SINGLE};
      pit_op_string_compare:
        time_d = {8'h00, `PIT_CYC_STR_SINGLE};
      pit_op_repeat_block: time_d = blk_rep;
      pit_op_repeat_string: time_d = str_rep;
      default: time_d = {8'h00, ac_instr.op_cycles} + mc;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      time_valid <= 1'b0;
      exec_time <= 16'h0000;
      mode_illegal <= 1'b0;
      cache_bypass <= 1'b0;
    end
    else
    begin
      time_valid <= accept;
      if (accept)
      begin
        exec_time <= time_d;
        mode_illegal <= illegal_w;
        // operand fetch treated as a miss
        cache_bypass <= (ac_instr.op == pit_op_decrement_interlocked);
      end
    end
  end
endmodule
`default_nettype wire

// [inc/pit_consts.svh]
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH
// processor cycle = two clock phases
`define PIT_PHASES_PER_CYCLE 2
`define PIT_STALL_ADJACENT 4'h2
`define PIT_STALL_GAP_ONE 4'h1
`define PIT_CYC_CHECK 8'h08
`define PIT_CYC_DEC_ILK 8'h04
`define PIT_CYC_BLK_SINGLE 8'h07
`define PIT_CYC_STR_SINGLE 8'h08
`define PIT_CYC_BLK_REP_BASE 8'h05
`define PIT_CYC_BLK_REP_STEP 8'h04
`define PIT_CYC_STR_REP_BASE 8'h04
`define PIT_CYC_STR_REP_STEP 8'h05
`define PIT_DIVW_C1 8'h05
`define PIT_DIVW_C2 8'h07
`define PIT_DIVW_C3 8'h19
`define PIT_LONG_SIGNED_QUOTIENT_C1 8'h04
`define PIT_LONG_SIGNED_QUOTIENT_C2 8'h06
`define PIT_LONG_SIGNED_QUOTIENT_C3 8'h26
`define PIT_REGS 16
`endif

// [inc/pit_pkg.sv]
package pit_pkg;
  typedef enum logic [1:0] {
    pit_rep_compact = 2'h0,
    pit_rep_segmented = 2'h1,
    pit_rep_linear = 2'h2
  } pit_rep_t;
  typedef enum logic [2:0] {
    pit_am_reg = 3'h0,
    pit_am_imm = 3'h1,
    pit_am_register_pointer_mode = 3'h2,
    pit_am_direct_address_mode = 3'h3,
    pit_am_indexed = 3'h4,
    pit_am_base = 3'h5,
    pit_am_pointer_plus_index_mode = 3'h6,
    pit_am_pc_relative_mode = 3'h7
  } pit_am_t;
  // relative-indexed has no code above; flagged separately
  typedef enum logic [3:0] {
    pit_op_simple = 4'h0,
    pit_op_bounds_check = 4'h1,
    pit_op_decrement_interlocked = 4'h2,
    pit_op_div = 4'h3,
    pit_op_block_compare = 4'h4,
    pit_op_string_compare = 4'h5,
    pit_op_repeat_block = 4'h6,
    pit_op_repeat_string = 4'h7
  } pit_op_t;
  typedef struct packed {
    logic valid;
    pit_op_t op;
    logic [7:0] op_cycles;
    pit_am_t mode;
    logic rel_indexed;
    logic imm_long;
    logic [1:0] ext_words;
    logic is_long;
    logic [1:0] div_case;
    logic [7:0] iters;
    logic multi_write;
    logic [15:0] wr_mask;
    logic [15:0] ac_mask;
  } pit_instr_t;
endpackage

// [hw/pit_mode_cost.sv]
`timescale 1ns/1ps
`default_nettype none
module pit_mode_cost
(
  // decode
  input wire pit_pkg::pit_am_t mode,
  input wire logic rel_indexed,
  input wire logic imm_long,
  input wire logic [1:0] ext_words,
  input wire pit_pkg::pit_rep_t rep,
  // result
  output logic [7:0] cost,
  output logic illegal
);
  import pit_pkg::*;
  wire compact = (rep == pit_rep_compact);
  wire multi_ext = (ext_words != 2'h1);
  always_comb
  begin
    cost = 8'h00;
    illegal = 1'b0;
    if (rel_indexed)
    begin
      cost = compact ? 8'h00 : 8'h02;
      illegal = compact;
    end
    else
    begin
      unique case (mode)
        pit_am_reg, pit_am_register_pointer_mode: cost = 8'h00;
        pit_am_imm: cost = imm_long ? 8'h01 : 8'h00;
        pit_am_direct_address_mode, pit_am_indexed:
          cost = (!compact && multi_ext) ? 8'h01 : 8'h00;
        pit_am_base:
          cost = (!compact && multi_ext) ? 8'h01 : 8'h00;
        pit_am_pointer_plus_index_mode:
          cost = (compact || multi_ext) ? 8'h02 : 8'h01;
        pit_am_pc_relative_mode: cost = 8'h01;
      endcase
    end
  end
endmodule
`default_nettype wire

// [sim/pit_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pit_core_chk
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // inputs
  input wire pit_pkg::pit_instr_t ac_instr,
  input wire pit_pkg::pit_rep_t rep,
  input wire logic cache_interlock,
  // outputs
  input wire logic cycle_en,
  input wire logic hold_front,
  input wire logic advance_back,
  input wire logic [3:0] stall_left,
  input wire logic time_valid,
  input wire logic [15:0] exec_time,
  input wire logic mode_illegal,
  input wire logic cache_bypass
);
  import pit_pkg::*;
  // ************
  // properties
  // ************
  wire acc = cycle_en && ac_instr.valid && !hold_front;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  chk_back_follows_cycle: assert property (advance_back == cycle_en)
    else $error("back stages not on processor cycle");
  chk_cycle_two_phase: assert property (cycle_en |=> !cycle_en ##1 cycle_en)
    else $error("processor cycle not two clocks");
  chk_accept_reports: assert property (acc |=> time_valid)
    else $error("accepted instruction without timing");
  chk_report_cause: assert property (time_valid |-> $past(acc))
    else $error("timing pulse without accept");
  chk_cache_holds: assert property (cache_interlock |-> hold_front)
    else $error("cache interlock did not hold front");
  chk_stall_bound: assert property (stall_left <= 4'h2)
    else $error("stall count above two");
  chk_stall_holds: assert property (stall_left != 4'h0 |-> hold_front)
    else $error("front moved during stall");
  chk_dec_time: assert property (acc && ac_instr.op == pit_op_decrement_interlocked
    |=> exec_time == 16'h0004 && cache_bypass)
    else $error("interlocked decrement timing wrong");
  chk_check_time: assert property (acc && ac_instr.op == pit_op_bounds_check &&
    ac_instr.mode == pit_am_reg && !ac_instr.rel_indexed
    |=> exec_time == 16'h0008)
    else $error("bounds check timing wrong");
  cover property (stall_left == 4'h1);
  cover property (acc && ac_instr.op == pit_op_div);
  cover property (cache_interlock && cycle_en);
endmodule
bind pit_core pit_core_chk u_chk (.mclk(mclk), .srst(srst),
  .ac_instr(ac_instr), .rep(rep), .cache_interlock(cache_interlock),
  .cycle_en(cycle_en), .hold_front(hold_front), .advance_back(advance_back),
  .stall_left(stall_left), .time_valid(time_valid), .exec_time(exec_time),
  .mode_illegal(mode_illegal), .cache_bypass(cache_bypass));
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pit_pkg::*;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] md;
    logic [1:0] ew;
    logic [1:0] rp;
    logic lg;
    logic [1:0] dc;
    logic [7:0] ex;
  } pit_row_t;
  // ************
  // table rows
  // ************
  localparam pit_row_t rows [18] = '{
    '{4'h0,3'h0,2'h0,2'h0,1'h0,2'h0,8'h01}, '{4'h0,3'h3,2'h2,2'h1,1'h0,2'h0,8'h02},
    '{4'h0,3'h4,2'h1,2'h2,1'h0,2'h0,8'h01}, '{4'h0,3'h5,2'h3,2'h1,1'h0,2'h0,8'h02},
    '{4'h0,3'h6,2'h0,2'h0,1'h0,2'h0,8'h03}, '{4'h0,3'h7,2'h3,2'h2,1'h0,2'h0,8'h02},
    '{4'h1,3'h7,2'h0,2'h0,1'h0,2'h0,8'h09}, '{4'h2,3'h0,2'h0,2'h0,1'h0,2'h0,8'h04},
    '{4'h3,3'h0,2'h0,2'h0,1'h0,2'h0,8'h05}, '{4'h3,3'h0,2'h0,2'h0,1'h0,2'h1,8'h07},
    '{4'h3,3'h0,2'h0,2'h0,1'h0,2'h2,8'h19}, '{4'h3,3'h0,2'h0,2'h0,1'h1,2'h0,8'h04},
    '{4'h3,3'h0,2'h0,2'h0,1'h1,2'h1,8'h06}, '{4'h3,3'h0,2'h0,2'h0,1'h1,2'h3,8'h26},
    '{4'h4,3'h2,2'h0,2'h0,1'h0,2'h0,8'h07}, '{4'h5,3'h2,2'h0,2'h0,1'h0,2'h0,8'h08},
    '{4'h6,3'h2,2'h0,2'h0,1'h0,2'h0,8'h11}, '{4'h7,3'h2,2'h0,2'h0,1'h0,2'h0,8'h13}};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  pit_instr_t ac_instr = '0;
  pit_rep_t rep = pit_rep_compact;
  logic cache_interlock = 1'b0;
  logic cycle_en, hold_front, advance_back, time_valid, mode_illegal;
  logic cache_bypass, tv, mi, cb;
  logic [3:0] stall_left;
  logic [15:0] exec_time, et;
  int n_fail = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int st;
  pit_instr_t i;
  pit_core dut (.mclk(mclk), .srst(srst), .ac_instr(ac_instr), .rep(rep),
    .cache_interlock(cache_interlock), .cycle_en(cycle_en),
    .hold_front(hold_front), .advance_back(advance_back),
    .stall_left(stall_left), .time_valid(time_valid), .exec_time(exec_time),
    .mode_illegal(mode_illegal), .cache_bypass(cache_bypass));
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // called at a rising edge; returns at the rising edge one clock after the accepting edge
  task automatic send(input pit_instr_t x, input pit_rep_t r);
    logic acc;
    st = 0;
    acc = 1'b0;
    ac_instr <= x;
    rep <= r;
    while (!acc)
    begin
      @(negedge mclk);
      acc = cycle_en && !hold_front;
      if (cycle_en && hold_front)
        st++;
      @(posedge mclk);
    end
    @(negedge mclk);
    {tv, et, mi, cb} = {time_valid, exec_time, mode_illegal, cache_bypass};
    @(posedge mclk);
  endtask
  task automatic hz(input logic [15:0] w, input logic m, input logic g,
    input logic [15:0] e);
    pit_instr_t x;
    x = '0;
    x.valid = 1'b1;
    x.op_cycles = 8'h01;
    x.wr_mask = w;
    x.multi_write = m;
    send(x, pit_rep_linear);
    {x.wr_mask, x.multi_write} = '0;
    if (g)
      send(x, pit_rep_linear);
    x.ac_mask = 16'h0204;
    send(x, pit_rep_linear);
    chk("stall cycles", e, st[15:0]);
  endtask
  always @(posedge mclk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  initial
  begin
    @(posedge mclk);
    @(negedge mclk);
    chk("cycle_en in reset", 16'h0, {15'h0, cycle_en});
    chk("stall in reset", 16'h0, {12'h0, stall_left});
    @(posedge mclk);
    srst <= 1'b0;
    foreach (rows[k])
    begin
      i = '0;
      i.valid = 1'b1;
      i.op = pit_op_t'(rows[k].op);
      i.op_cycles = 8'h01;
      i.mode = pit_am_t'(rows[k].md);
      {i.ext_words, i.is_long, i.div_case} = {rows[k].ew, rows[k].lg, rows[k].dc};
      i.iters = 8'h03;
      send(i, pit_rep_t'(rows[k].rp));
      chk("time_valid", 16'h1, {15'h0, tv});
      chk("exec_time", {8'h00, rows[k].ex}, et);
      chk("bypass", {15'h0, rows[k].op == 4'h2}, {15'h0, cb});
    end
    hz(16'h0004, 1'b0, 1'b0, 16'h2);
    hz(16'h0004, 1'b0, 1'b1, 16'h1);
    hz(16'h0000, 1'b1, 1'b0, 16'h2);
    hz(16'h0010, 1'b0, 1'b0, 16'h0);
    i = '0;
    i.valid = 1'b1;
    i.op_cycles = 8'h01;
    i.rel_indexed = 1'b1;
    send(i, pit_rep_compact);
    chk("illegal compact", 16'h1, {15'h0, mi});
    send(i, pit_rep_segmented);
    chk("rel indexed time", 16'h3, et);
    i.rel_indexed = 1'b0;
    cache_interlock <= 1'b1;
    repeat (4)
    begin
      @(posedge mclk);
      @(negedge mclk);
      chk("cache hold", 16'h1, {15'h0, hold_front});
      chk("held no accept", 16'h0, {15'h0, time_valid});
    end
    @(posedge mclk);
    cache_interlock <= 1'b0;
    send(i, pit_rep_compact);
    chk("after cache", 16'h1, {15'h0, tv});
    ac_instr <= '0;
    report_and_stop;
  end
endmodule
`default_nettype wire
